//--- core/psb_defines.vh
// constants for the dual-target two-wire slave of the supply module
`ifndef PSB_DEFINES_VH
`define PSB_DEFINES_VH
`define PSB_CTRL_BASE    7'h58
`define PSB_EE_BASE      7'h50
`define PSB_EE_DEPTH     256
`define PSB_BLOCK_MAX    8'hFF
`define PSB_CLK_MHZ      100
`define PSB_TIMEOUT_MS   25
`define PSB_RECOVER_MS   10
`define PSB_STRETCH_MS   1
`define PSB_CMD_T_INLET  8'h8E
`define PSB_CMD_T_OUTLET 8'h8F
`define PSB_CMD_T_ORING  8'h8D
`define PSB_CMD_T_SR     8'hD2
`define PSB_CMD_T_PRI    8'hD3
`define PSB_CMD_T_AUX    8'hD4
`define PSB_CMD_BLOCK_RD 8'h9A
`define PSB_CMD_BLOCK_WR 8'hB0
`define PSB_STRAP_WAIT   2'h2
`define PSB_BLOCK_LEN    8'h0C
`endif

//--- core/psb_ram.v
// user byte memory of the eeprom target, registered read data
`timescale 1ns/10ps
`default_nettype none
`include "psb_defines.vh"
module psb_ram (
  input  wire       clock,   // system clock
  input  wire       ce,      // clock enable
  input  wire       we,      // write strobe
  input  wire [7:0] addr,    // byte location
  input  wire [7:0] wdata,   // write data
  output reg  [7:0] rdata    // registered read data
);
  // ****************
  // storage
  // ****************
  reg [7:0] mem [0:`PSB_EE_DEPTH-1]; // 256 user bytes

  // write and registered read
  always @(posedge clock) begin
    if (ce) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end
endmodule // psb_ram
`default_nettype wire

//--- core/psb_slave.v
// dual-target two-wire slave: controller commands plus user eeprom
`timescale 1ns/10ps
`default_nettype none
`include "psb_defines.vh"
module psb_slave (
  input  wire        clock,                    // 100 MHz system clock
  input  wire        nrst,                     // async reset, active low
  input  wire        ce,                       // clock enable
  input  wire        scl_in,                   // serial clock pin level
  output wire        scl_out,                  // serial clock drive value
  output wire        scl_oe,                   // serial clock pulled low
  input  wire        sda_in,                   // data pin level
  output wire        sda_out,                  // data drive value
  output wire        sda_oe,                   // data pulled low
  input  wire        addr_strap_low,           // strap bit 0
  input  wire        addr_strap_mid,           // strap bit 1
  input  wire        addr_strap_high_reserved, // strap bit 2, unused
  input  wire        shutdown_event,           // any shutdown present
  input  wire        warning_event,            // any warning present
  output reg         fault_alert_out_n,        // alert, active low
  input  wire [95:0] temp_readings,            // six 16-bit readings
  output reg  [7:0]  cmd_code,                 // last command code
  output reg  [15:0] cmd_data,                 // last write data
  output reg  [7:0]  cmd_len,                  // data bytes of last write
  output reg         cmd_strobe                // pulse: write finished
);
  // ****************
  // timing constants
  // ****************
  localparam integer CYC_MS = `PSB_CLK_MHZ * 1000;
  parameter integer TIMEOUT_CYC = `PSB_TIMEOUT_MS * CYC_MS;
  // clock stretch is never used, so 1 ms limit is held trivially
  localparam integer STRETCH_CYC = `PSB_STRETCH_MS * CYC_MS;
  // sampling at the system clock keeps up with a 100 kbps bus
  // logic sits on the always-on supply, so the bus stays reachable
  // from either the input feed or a live shared rail

  // states
  localparam [2:0] S_IDLE = 3'h0;  // wait for start
  localparam [2:0] S_ADDR = 3'h1;  // shift address byte
  localparam [2:0] S_RX   = 3'h2;  // shift write byte
  localparam [2:0] S_ACK  = 3'h3;  // drive ack bit
  localparam [2:0] S_TX   = 3'h4;  // shift read byte
  localparam [2:0] S_MACK = 3'h5;  // sample master ack
  localparam [2:0] S_SKIP = 3'h6;  // not addressed or read ended by nack, released

  // ****************
  // pin synchronisers
  // ****************
  reg [1:0] scl_sy;  // two-flop scl
  reg [1:0] sda_sy;  // two-flop sda
  reg       scl_q;   // previous synced scl
  reg       sda_q;   // previous synced sda
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      scl_sy <= 2'h3;
      sda_sy <= 2'h3;
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
    end else if (ce) begin
      scl_sy <= {scl_sy[0], scl_in};
      sda_sy <= {sda_sy[0], sda_in};
      scl_q  <= scl_sy[1];
      sda_q  <= sda_sy[1];
    end
  end
  wire scl = scl_sy[1];
  wire sda = sda_sy[1];
  wire scl_rise = scl & ~scl_q;                 // sample point
  wire scl_fall = ~scl & scl_q;                 // shift point
  wire start_c  = scl & scl_q & sda_q & ~sda;   // start or restart
  wire stop_c   = scl & scl_q & ~sda_q & sda;   // stop

  // ****************
  // strap capture
  // ****************
  reg       strap_taken; // straps latched
  reg [2:0] strap;       // latched strap value
  reg [1:0] strap_s0;    // first strap flop, mid and low
  reg [1:0] strap_s1;    // second strap flop
  reg [1:0] strap_age;   // cycles since reset release
  // strap pins pass two flops, then are latched once
  // reserved strap pin is not read at all: it counts as zero
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      strap_taken <= 1'b0;
      strap       <= 3'h0;
      strap_s0    <= 2'h3;
      strap_s1    <= 2'h3;
      strap_age   <= 2'h0;
    end else if (ce) begin
      strap_s0 <= {addr_strap_mid, addr_strap_low};
      strap_s1 <= strap_s0;
      if (!strap_taken) begin
        if (strap_age == `PSB_STRAP_WAIT) begin
          // latch only once both flops hold the pin level
          strap_taken <= 1'b1;
          // pads pulled up: open reads one, grounded zero
          strap <= {1'b0, strap_s1};
        end else begin
          strap_age <= strap_age + 2'h1; // still filling the flops
        end
      end
    end
  end
  wire [6:0] ctrl_addr = `PSB_CTRL_BASE + {5'h0, strap[1:0]};
  wire [6:0] ee_addr   = `PSB_EE_BASE + {5'h0, strap[1:0]};

  // ****************
  // alert output
  // ****************
  // or of both event groups, low while any present
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fault_alert_out_n <= 1'b1;
    end else if (ce) begin
      fault_alert_out_n <= ~(shutdown_event | warning_event);
    end
  end

  // ****************
  // protocol engine
  // ****************
  reg [2:0]  state;     // engine state
  reg [7:0]  sh;        // shift register
  reg [2:0]  bitn;      // bit counter
  reg        is_ee;     // eeprom target selected
  reg        rd;        // read direction
  reg [7:0]  nbytes;    // bytes after address
  reg [7:0]  ptr;       // eeprom location
  reg [7:0]  cmd;       // current command
  reg [15:0] wdat;      // collected write data
  reg        sda_low;   // drive sda low
  reg [7:0]  txb;       // byte being sent
  reg        ee_we;     // memory write strobe
  reg [23:0] low_cnt;   // scl low counter
  wire [7:0] ee_rdata;  // memory read data

  // temperature word for a command code
  reg [15:0] tword;
  always @* begin
    case (cmd)
      `PSB_CMD_T_INLET:  tword = temp_readings[15:0];
      `PSB_CMD_T_SR:     tword = temp_readings[31:16];
      `PSB_CMD_T_OUTLET: tword = temp_readings[47:32];
      `PSB_CMD_T_ORING:  tword = temp_readings[63:48];
      `PSB_CMD_T_PRI:    tword = temp_readings[79:64];
      `PSB_CMD_T_AUX:    tword = temp_readings[95:80];
      default:           tword = 16'h0000;
    endcase
  end

  // read byte source: byte, word, or count byte then block of 12 reading bytes
  reg [7:0] ctx;
  always @* begin
    if (cmd == `PSB_CMD_BLOCK_RD) begin
      // count byte, then all reading bytes from bit 0 up
      if (nbytes == 8'h00) begin
        ctx = `PSB_BLOCK_LEN;
      end else if (nbytes > `PSB_BLOCK_LEN) begin
        ctx = 8'hFF; // past the table: released bus level
      end else begin
        ctx = temp_readings[{nbytes[3:0] - 4'h1, 3'h0} +: 8];
      end
    end else begin
      ctx = nbytes[0] ? tword[15:8] : tword[7:0]; // low then high
    end
  end

  // clock held low too long by someone: abandon the transfer
  wire tmo = (low_cnt >= TIMEOUT_CYC[23:0]);

  // scl low watchdog
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      low_cnt <= 24'h000000;
    end else if (ce) begin
      if (scl || state == S_IDLE) begin
        low_cnt <= 24'h000000;
      end else if (!tmo) begin
        low_cnt <= low_cnt + 24'h000001;
      end
    end
  end

  // main sequencer
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= S_IDLE; sh <= 8'h00; bitn <= 3'h0; is_ee <= 1'b0;
      rd <= 1'b0; nbytes <= 8'h00; ptr <= 8'h00; cmd <= 8'h00;
      wdat <= 16'h0000; sda_low <= 1'b0; txb <= 8'h00; ee_we <= 1'b0;
      cmd_code <= 8'h00; cmd_data <= 16'h0000; cmd_len <= 8'h00;
      cmd_strobe <= 1'b0;
    end else if (ce) begin
      ee_we      <= 1'b0;
      cmd_strobe <= 1'b0;
      if (tmo) begin
        // abandon on long clock low, ready at once
        state <= S_IDLE; sda_low <= 1'b0;
      end else if (start_c) begin
        // start at any point restarts framing
        // stale shift bits must not look like an address
        state <= S_ADDR; bitn <= 3'h0; sda_low <= 1'b0; sh <= 8'h00;
      end else if (stop_c) begin
        // stop ends transfer; finish write forms
        if ((state == S_RX || state == S_ACK) && !rd && !is_ee
            && nbytes != 8'h00) begin
          cmd_code <= cmd; cmd_data <= wdat;
          cmd_len <= nbytes - 8'h01; cmd_strobe <= 1'b1;
        end
        state <= S_IDLE; sda_low <= 1'b0;
      end else begin
        case (state)
          S_IDLE: sda_low <= 1'b0; // only ever a target
          // collect eight bits on rising clock, act on the fall
          S_ADDR, S_RX: begin
            if (scl_rise) begin
              sh   <= {sh[6:0], sda};
              bitn <= bitn + 3'h1;
            end else if (scl_fall && bitn == 3'h0 && state == S_ADDR
                         && sh != 8'h00) begin
              // lsb is direction
              if (sh[7:1] == ctrl_addr || sh[7:1] == ee_addr) begin
                is_ee <= (sh[7:1] == ee_addr);
                rd <= sh[0]; sda_low <= 1'b1; state <= S_ACK;
                // byte count restarts for either direction, so a read
                // after a command begins with the low byte
                nbytes <= 8'h00;
              end else begin
                state <= S_SKIP; // no ack
              end
            end else if (scl_fall && bitn == 3'h0 && state == S_RX) begin
              sda_low <= 1'b1; state <= S_ACK;
              if (nbytes == 8'h00) begin
                ptr <= sh; cmd <= sh; // location or command
              end else if (is_ee) begin
                ee_we <= 1'b1;        // store at location
              end else if (nbytes == 8'h01) begin
                wdat[7:0] <= sh;
              end else begin
                wdat[15:8] <= sh;     // later block bytes overwrite high byte
              end
              if (nbytes != `PSB_BLOCK_MAX) nbytes <= nbytes + 8'h01;
            end
          end
          // release ack, or launch first read bit, on the clock fall
          S_ACK: begin
            if (scl_fall) begin
              if (rd) begin
                state   <= S_TX;
                txb     <= is_ee ? ee_rdata : ctx;
                sda_low <= is_ee ? ~ee_rdata[7] : ~ctx[7];
                bitn    <= 3'h0;
              end else begin
                sda_low <= 1'b0; state <= S_RX; bitn <= 3'h0; sh <= 8'h00;
              end
            end
          end
          // shift out msb first, release for the master's ack
          S_TX: begin
            if (scl_fall) begin
              bitn <= bitn + 3'h1;
              if (bitn == 3'h7) begin
                sda_low <= 1'b0; state <= S_MACK;
                if (is_ee) ptr <= ptr + 8'h01;
                if (nbytes != `PSB_BLOCK_MAX) nbytes <= nbytes + 8'h01;
              end else begin
                sda_low <= ~txb[3'h6 - bitn];
              end
            end
          end
          S_MACK: begin
            if (scl_rise) begin
              // nack ends read; ack continues
              state <= sda ? S_SKIP : S_ACK;
            end
          end
          S_SKIP: sda_low <= 1'b0;
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // ****************
  // user memory
  // ****************
  // memory address follows the location pointer
  psb_ram psb_ram_inst (
    .clock (clock),
    .ce    (ce),
    .we    (ee_we),
    .addr  (ptr),
    .wdata (sh),
    .rdata (ee_rdata)
  );

  // open-drain drive; clock never held
  assign sda_out = 1'b0;
  assign sda_oe  = sda_low;
  assign scl_out = 1'b0;
  assign scl_oe  = 1'b0;
endmodule // psb_slave
`default_nettype wire

//--- tb/psb_host.sv
// bus master model that drives the slave pins open-drain
`timescale 1ns/10ps
`default_nettype none
module psb_host (
  input  wire logic scl,     // resolved clock line
  input  wire logic sda,     // resolved data line
  output var  logic scl_low, // pull clock low
  output var  logic sda_low  // pull data low
);
  localparam int Q = 40; // quarter of the 160 ns bit time
  // both lines released, pull-ups take them high
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // start or repeated start, clock left low
  task automatic start();
    sda_low = 1'b0;
    #Q scl_low = 1'b0;
    #Q sda_low = 1'b1;
    #Q scl_low = 1'b1;
  endtask
  // stop, then the bus stays idle
  task automatic stop();
    #Q sda_low = 1'b1;
    #Q scl_low = 1'b0;
    #Q sda_low = 1'b0;
    #Q;
  endtask
  // one single-byte unit: eight bits msb first, then the ack bit
  task automatic xb(input logic [7:0] d, input logic k,
                    output logic [7:0] r, output logic a);
    logic [8:0] v;
    v = {d, k};
    for (int i = 8; i >= 0; i--) begin
      #Q sda_low = !v[i];
      #Q scl_low = 1'b0;
      #Q v[i] = sda;
      #Q scl_low = 1'b1;
    end
    r = v[8:1];
    a = v[0];
  endtask
endmodule // psb_host
`default_nettype wire

//--- tb/psb_slave_checker.sv
// concurrent checks on the pins of the two-wire slave
`timescale 1ns/10ps
`default_nettype none
module psb_slave_checker #(parameter integer TIMEOUT_CYC = 2000) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic shutdown_event,
  input wire logic warning_event,
  input wire logic fault_alert_out_n,
  input wire logic cmd_strobe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  int low_cnt; // cycles the clock line has been low
  // count clock-low time, saturating above the timeout
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) low_cnt <= 0;
    else if (scl_in) low_cnt <= 0;
    else if (low_cnt < TIMEOUT_CYC + 64) low_cnt <= low_cnt + 1;
  end
  sequence s_held;
    sda_oe [*8];
  endsequence
  a_no_stretch: assert property (!scl_oe)
    else $error("clock line pulled by slave");
  a_open_drain: assert property (!sda_out)
    else $error("data drive value not low");
  a_alert_set: assert property (
    (ce && (shutdown_event || warning_event)) |=> !fault_alert_out_n)
    else $error("alert missing");
  a_alert_clear: assert property (
    (ce && !(shutdown_event || warning_event)) |=> fault_alert_out_n)
    else $error("alert stuck");
  a_strobe_pulse: assert property (cmd_strobe |=> !cmd_strobe)
    else $error("strobe longer than one cycle");
  a_strobe_idle: assert property (cmd_strobe |-> scl_in && sda_in)
    else $error("strobe outside stop");
  a_drive_change: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data drive changed while clock high");
  a_drive_hold: assert property ($rose(sda_oe) |-> s_held)
    else $error("data drive dropped early");
  a_timeout_free: assert property (
    (low_cnt > TIMEOUT_CYC + 8) |-> !sda_oe)
    else $error("data held after timeout");
endmodule // psb_slave_checker
bind psb_slave psb_slave_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk_inst (
  .clock(clock), .nrst(nrst), .ce(ce), .scl_in(scl_in), .scl_oe(scl_oe),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .shutdown_event(shutdown_event), .warning_event(warning_event),
  .fault_alert_out_n(fault_alert_out_n), .cmd_strobe(cmd_strobe));
`default_nettype wire

//--- tb/psb_slave_bench.sv
// self-checking bench of the dual-target two-wire slave
`timescale 1ns/10ps
`default_nettype none
module psb_slave_bench;
  localparam int TMO = 2000; // shortened clock-low timeout
  localparam int EE_WAIT = 2000; // ns, shortened programming gap
  logic        clock = 1'b0; // system clock
  logic        nrst = 1'b0;  // reset, active low
  logic        ce = 1'b1;    // clock enable
  logic        sd = 1'b0;    // shutdown event
  logic        wn = 1'b0;    // warning event
  logic [2:0]  strap = 3'h5; // reserved, mid, low straps
  logic [95:0] temp = 96'h665544332211A1B2C3D41E5A; // readings
  wire  logic  scl, sda, scl_low, sda_low, scl_out, scl_oe, sda_out;
  wire  logic  sda_oe, alert_n, strb;
  wire  logic [7:0]  code, len;
  wire  logic [15:0] data;
  int errors = 0;
  int n_checks = 0;
  int strobes = 0;
  always #5 clock = ~clock;
  assign scl = !(scl_low | scl_oe);
  assign sda = !(sda_low | sda_oe);
  always @(posedge clock) if (strb === 1'b1) strobes <= strobes + 1;
  psb_slave #(.TIMEOUT_CYC(TMO)) psb_slave_inst (.clock(clock),
    .nrst(nrst), .ce(ce), .scl_in(scl), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strap_low(strap[0]), .addr_strap_mid(strap[1]),
    .addr_strap_high_reserved(strap[2]), .shutdown_event(sd),
    .warning_event(wn), .fault_alert_out_n(alert_n),
    .temp_readings(temp), .cmd_code(code), .cmd_data(data),
    .cmd_len(len), .cmd_strobe(strb));
  psb_host psb_host_inst (.scl(scl), .sda(sda), .scl_low(scl_low),
    .sda_low(sda_low));
  task automatic chk(input string n, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wb(input logic [7:0] b, input logic k);
    logic [7:0] r;
    logic a;
    psb_host_inst.xb(b, 1'b1, r, a);
    chk("ack", {15'h0, k}, {15'h0, a});
  endtask
  task automatic rd_word(input logic [7:0] c, output logic [15:0] w);
    logic a;
    psb_host_inst.start();
    wb(8'hB2, 1'b0);
    wb(c, 1'b0);
    psb_host_inst.start();
    wb(8'hB3, 1'b0);
    psb_host_inst.xb(8'hFF, 1'b0, w[7:0], a);
    psb_host_inst.xb(8'hFF, 1'b1, w[15:8], a);
    psb_host_inst.stop();
  endtask
  task automatic t_alert();
    for (int i = 0; i < 4; i++) begin
      @(posedge clock) {sd, wn} <= i[1:0];
      repeat (3) @(posedge clock);
      #1 chk("alert_n", {15'h0, i == 0}, {15'h0, alert_n});
    end
    // clock enable low freezes the alert although the events are gone
    @(posedge clock) begin
      {sd, wn} <= 2'h0;
      ce <= 1'b0;
    end
    repeat (3) @(posedge clock);
    #1 chk("alert_n frozen", 16'h0000, {15'h0, alert_n});
    @(posedge clock) ce <= 1'b1;
    repeat (3) @(posedge clock);
    #1 chk("alert_n resumed", 16'h0001, {15'h0, alert_n});
    chk("scl_out", 16'h0000, {15'h0, scl_out});
    $display("test alert done");
  endtask
  task automatic t_ee();
    logic [7:0] r;
    logic a;
    psb_host_inst.start();
    wb(8'hA2, 1'b0);
    wb(8'h3C, 1'b0);
    wb(8'hA5, 1'b0);
    psb_host_inst.stop();
    #EE_WAIT;
    psb_host_inst.start();
    wb(8'hA2, 1'b0);
    wb(8'h3C, 1'b0);
    psb_host_inst.start();
    wb(8'hA3, 1'b0);
    psb_host_inst.xb(8'hFF, 1'b1, r, a);
    psb_host_inst.stop();
    chk("eeprom byte", 16'h00A5, {8'h00, r});
    $display("test eeprom done");
  endtask
  task automatic t_miss();
    logic [7:0] m[3] = '{8'hC0, 8'hB0, 8'hBA};
    for (int i = 0; i < 3; i++) begin
      psb_host_inst.start();
      wb(m[i], 1'b1);
      psb_host_inst.stop();
    end
    $display("test unmatched done");
  endtask
  task automatic t_cwr();
    psb_host_inst.start();
    wb(8'hB2, 1'b0);
    wb(8'h21, 1'b0);
    wb(8'h34, 1'b0);
    wb(8'h12, 1'b0);
    psb_host_inst.stop();
    repeat (8) @(posedge clock);
    chk("cmd_code", 16'h0021, {8'h00, code});
    chk("cmd_data", 16'h1234, data);
    chk("cmd_len", 16'h0002, {8'h00, len});
    psb_host_inst.start();
    wb(8'hB2, 1'b0);
    wb(8'h03, 1'b0);
    psb_host_inst.stop();
    repeat (8) @(posedge clock);
    chk("cmd_len", 16'h0000, {8'h00, len});
    chk("strobes", 16'h0002, strobes[15:0]);
    $display("test command write done");
  endtask
  task automatic t_crd();
    logic [7:0] c[3] = '{8'h8E, 8'hD2, 8'h8F};
    logic [15:0] w;
    for (int k = 0; k < 3; k++) begin
      rd_word(c[k], w);
      chk("reading", temp[16*k +: 16], w);
    end
    $display("test command read done");
  endtask
  // block read: count byte, then reading bytes from bit 0 up
  task automatic t_blk();
    logic [7:0] r;
    logic a;
    psb_host_inst.start();
    wb(8'hB2, 1'b0);
    wb(8'h9A, 1'b0);
    psb_host_inst.start();
    wb(8'hB3, 1'b0);
    psb_host_inst.xb(8'hFF, 1'b0, r, a);
    chk("block count", 16'h000C, {8'h00, r});
    psb_host_inst.xb(8'hFF, 1'b0, r, a);
    chk("block byte 0", {8'h00, temp[7:0]}, {8'h00, r});
    psb_host_inst.xb(8'hFF, 1'b1, r, a);
    chk("block byte 1", {8'h00, temp[15:8]}, {8'h00, r});
    psb_host_inst.stop();
    $display("test block read done");
  endtask
  task automatic t_tmo();
    logic [15:0] w;
    psb_host_inst.start();
    wb(8'hB2, 1'b0);
    wb(8'h8E, 1'b0);
    psb_host_inst.start();
    wb(8'hB3, 1'b0);
    repeat (6) @(posedge clock);
    #1 chk("first bit", 16'h0001, {15'h0, sda_oe});
    repeat (TMO + 100) @(posedge clock);
    #1 chk("after timeout", 16'h0000, {15'h0, sda_oe});
    psb_host_inst.stop();
    rd_word(8'h8E, w);
    chk("recovered read", temp[15:0], w);
    $display("test timeout done");
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    t_alert();
    t_ee();
    t_miss();
    t_cwr();
    t_crd();
    t_blk();
    t_tmo();
    conclude();
  end
  initial begin
    #500000;
    errors++;
    conclude();
  end
endmodule // psb_slave_bench
`default_nettype wire
